// File: logic/lfs_consts.svh
// Timing, limit and encoding constants of the LED fault supervisor.
`ifndef LFS_CONSTS_SVH
`define LFS_CONSTS_SVH
`define LFS_CLK_HZ        20000000
`define LFS_CLK_MHZ       (`LFS_CLK_HZ / 1000000)
`define LFS_UV_DELAY_NS   50000
`define LFS_UV_CYC        ((`LFS_UV_DELAY_NS * `LFS_CLK_MHZ + 999) / 1000)
`define LFS_SHDN_CYC      32750
`define LFS_DITH_HZ       12500
`define LFS_DITH_HALF_CYC (`LFS_CLK_HZ / (2 * `LFS_DITH_HZ))
`define LFS_DITH_LO_PM    950
`define LFS_DITH_HI_PM    1050
`define LFS_DITH_SHIFT    3
`define LFS_PM_W          11
`define LFS_LEDS          4
`define LFS_ST_OFF        3'h0
`define LFS_ST_START      3'h1
`define LFS_ST_SOFT       3'h3
`define LFS_ST_RUN        3'h2
`define LFS_ST_LATCH      3'h6
`define LFS_ST_SHDN       3'h7
`endif

// File: logic/lfs_pkg.sv
// Types shared by the LED fault supervisor files.
`include "lfs_consts.svh"
package lfs_pkg;
  // Supervisor states, Gray coded along off-start-soft-run.
  typedef enum logic [2:0] {
    LFS_OFF   = `LFS_ST_OFF,
    LFS_START = `LFS_ST_START,
    LFS_SOFT  = `LFS_ST_SOFT,
    LFS_RUN   = `LFS_ST_RUN,
    LFS_LATCH = `LFS_ST_LATCH,
    LFS_SHDN  = `LFS_ST_SHDN
  } lfs_state_e;
  // Comparator outputs from the analog front end, all active high.
  typedef struct packed {
    logic cyc_ilim;
    logic sec_ilim;
    logic in_trip;
    logic sw_ovp;
    logic out_ovp;
    logic led_current_program_pin_oc;
    logic frequency_program_pin_oc;
  } lfs_cmp_s;
  // Latched fault record.
  typedef struct packed {
    logic sec_ilim;
    logic in_trip;
    logic sw_ovp;
  } lfs_latch_s;
endpackage

// File: logic/lfs_dither.sv
// Triangle generator producing the switching frequency factor in per mille.
`timescale 1ns/10ps
`include "lfs_consts.svh"
module lfs_dither #(
  parameter int HALF_CYC = `LFS_DITH_HALF_CYC
) (
  input  wire logic                 clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 ce_i,
  output logic [`LFS_PM_W-1:0]      factor_o
);
  localparam int CW = $clog2(HALF_CYC + 1);
  localparam logic [CW-1:0] TOP = HALF_CYC[CW-1:0];
  localparam logic [`LFS_PM_W-1:0] LO = `LFS_PM_W'(`LFS_DITH_LO_PM);
  logic [CW-1:0] cnt_reg;
  logic          up_reg;

  // Counter ramps up for half a period and down for the other half.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_reg <= '0;
      up_reg  <= 1'b1;
    end else if (ce_i) begin
      if (up_reg) begin
        if (cnt_reg == TOP - 1'b1) begin
          up_reg <= 1'b0;
        end
        cnt_reg <= cnt_reg + 1'b1;
      end else begin
        if (cnt_reg == {{(CW-1){1'b0}}, 1'b1}) begin
          up_reg <= 1'b1;
        end
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  // Scaled count offsets the low factor, spanning the full sweep.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      factor_o <= LO;
    end else if (ce_i) begin
      factor_o <= LO + `LFS_PM_W'(cnt_reg >> `LFS_DITH_SHIFT);
    end
  end
endmodule

// File: logic/lfs_supervisor.sv
// Fault supervisor and enable sequencer of the boost LED driver.
`timescale 1ns/10ps
`include "lfs_consts.svh"
module lfs_supervisor #(
  parameter int N_LED    = `LFS_LEDS,
  parameter int SHDN_CYC = `LFS_SHDN_CYC,
  parameter int UV_CYC   = `LFS_UV_CYC,
  parameter int DITH_CYC = `LFS_DITH_HALF_CYC
) (
  input  wire logic                 clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 ce_i,
  input  wire logic                 uv_low_i,
  input  wire logic                 dim_i,
  input  wire logic                 ss_done_i,
  input  wire lfs_pkg::lfs_cmp_s    cmp_i,
  input  wire logic [N_LED-1:0]     led_short_i,
  input  wire logic [N_LED-1:0]     led_noreg_i,
  output logic                      boost_en_o,
  output logic                      on_kill_o,
  output logic                      disc_gate_en_o,
  output logic [N_LED-1:0]          sink_en_o,
  output logic                      fault_n_o,
  output logic                      shutdown_o,
  output logic                      raise_vout_o,
  output logic [`LFS_PM_W-1:0]      freq_factor_o
);
  import lfs_pkg::*;

  localparam int UVW = $clog2(UV_CYC + 1);
  localparam int DW  = $clog2(SHDN_CYC + 1);
  localparam logic [UVW-1:0] UV_LIM = UV_CYC[UVW-1:0];
  localparam logic [DW-1:0]  DM_LIM = SHDN_CYC[DW-1:0];

  logic [UVW-1:0]        uv_cnt_reg;
  logic                  uv_lock_reg;
  logic [DW-1:0]         dim_cnt_reg;
  logic                  shdn_hit;
  lfs_latch_s            latch_reg;
  lfs_latch_s            latch_set;
  lfs_latch_s            latch_next;
  logic                  trip_any;
  lfs_state_e            state_reg;
  lfs_state_e            state_next;
  logic [N_LED-1:0]      mask_reg;
  logic                  boost_next;
  logic                  kill_next;
  logic                  disc_next;
  logic [N_LED-1:0]      sink_next;
  logic                  fault_n_next;
  logic                  raise_next;
  logic [`LFS_PM_W-1:0]  factor_w;

  // Function telling whether the power stage is allowed to run in a state.
  function automatic logic lfs_active(input lfs_state_e st);
    lfs_active = (st == LFS_SOFT) || (st == LFS_RUN);
  endfunction

  // Undervoltage filter: lock only after a continuous low over the limit.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      uv_cnt_reg  <= '0;
      uv_lock_reg <= 1'b0;
    end else if (ce_i) begin
      if (!uv_low_i) begin
        uv_cnt_reg  <= '0;
        uv_lock_reg <= 1'b0;
      end else if (uv_cnt_reg == UV_LIM) begin
        uv_lock_reg <= 1'b1;
      end else begin
        uv_cnt_reg <= uv_cnt_reg + 1'b1;
      end
    end
  end

  // Dimming low-time counter, restarted by any high level.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      dim_cnt_reg <= '0;
    end else if (ce_i) begin
      if (dim_i) begin
        dim_cnt_reg <= '0;
      end else if (dim_cnt_reg != DM_LIM) begin
        dim_cnt_reg <= dim_cnt_reg + 1'b1;
      end
    end
  end

  // Shutdown request after the low time has run out.
  assign shdn_hit = !dim_i && (dim_cnt_reg == DM_LIM);

  // Latched faults: clear on shutdown or lockout, a new trip wins.
  always_comb begin
    latch_set.sec_ilim = cmp_i.sec_ilim;
    latch_set.in_trip  = cmp_i.in_trip;
    latch_set.sw_ovp   = cmp_i.sw_ovp;
    latch_next = latch_reg;
    if (shdn_hit || uv_lock_reg) begin
      latch_next = '0;
    end
    latch_next = latch_next | latch_set;
  end

  // Trip is seen in the cycle of the comparator or while stored.
  assign trip_any = (|latch_set) || (|latch_reg);

  // Latch register update.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      latch_reg <= '0;
    end else if (ce_i) begin
      latch_reg <= latch_next;
    end
  end

  // Next state of the sequencer; lockout has top priority.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      LFS_OFF: begin
        if (shdn_hit) begin
          state_next = LFS_SHDN;
        end else if (trip_any) begin
          state_next = LFS_LATCH;
        end else begin
          state_next = LFS_START;
        end
      end
      LFS_START: begin
        if (shdn_hit) begin
          state_next = LFS_SHDN;
        end else if (trip_any) begin
          state_next = LFS_LATCH;
        end else if (!(|led_short_i) && !cmp_i.frequency_program_pin_oc) begin
          state_next = LFS_SOFT;
        end
      end
      LFS_SOFT, LFS_RUN: begin
        if (shdn_hit) begin
          state_next = LFS_SHDN;
        end else if (trip_any) begin
          state_next = LFS_LATCH;
        end else if (cmp_i.frequency_program_pin_oc) begin
          state_next = LFS_START;
        end else if (state_reg == LFS_SOFT && ss_done_i) begin
          state_next = LFS_RUN;
        end
      end
      LFS_LATCH: begin
        if (shdn_hit) begin
          state_next = LFS_SHDN;
        end
      end
      LFS_SHDN: begin
        if (dim_i) begin
          state_next = LFS_START;
        end
      end
      default: begin
        state_next = LFS_OFF;
      end
    endcase
    if (uv_lock_reg) begin
      state_next = LFS_OFF;
    end
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= LFS_OFF;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  // Open string mask: strings out of regulation drop at overvoltage.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mask_reg <= '1;
    end else if (ce_i) begin
      if (state_reg != LFS_RUN) begin
        mask_reg <= '1;
      end else if (cmp_i.out_ovp) begin
        mask_reg <= mask_reg & ~led_noreg_i;
      end
    end
  end

  // Drive decisions for the power stage, taken from the next state.
  always_comb begin
    boost_next   = 1'b0;
    kill_next    = 1'b0;
    disc_next    = 1'b0;
    sink_next    = '0;
    raise_next   = 1'b0;
    fault_n_next = 1'b1;
    if (state_next == LFS_START) begin
      disc_next = !cmp_i.frequency_program_pin_oc;
    end else if (lfs_active(state_next)) begin
      disc_next  = 1'b1;
      boost_next = !cmp_i.led_current_program_pin_oc && !cmp_i.out_ovp;
      kill_next  = cmp_i.cyc_ilim;
      if (!cmp_i.led_current_program_pin_oc && dim_i) begin
        sink_next = mask_reg;
      end
      raise_next = (state_next == LFS_RUN) && !cmp_i.out_ovp &&
                   (|(led_noreg_i & mask_reg));
    end
    if (state_next == LFS_LATCH) begin
      fault_n_next = 1'b0;
    end else if (state_next == LFS_START && cmp_i.frequency_program_pin_oc) begin
      fault_n_next = 1'b0;
    end
  end

  // Registered power stage outputs.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      boost_en_o     <= 1'b0;
      on_kill_o      <= 1'b0;
      disc_gate_en_o <= 1'b0;
      sink_en_o      <= '0;
      fault_n_o      <= 1'b1;
      raise_vout_o   <= 1'b0;
      shutdown_o     <= 1'b0;
    end else if (ce_i) begin
      boost_en_o     <= boost_next;
      on_kill_o      <= kill_next;
      disc_gate_en_o <= disc_next;
      sink_en_o      <= sink_next;
      fault_n_o      <= fault_n_next;
      raise_vout_o   <= raise_next;
      shutdown_o     <= (state_next == LFS_SHDN);
    end
  end

  // Frequency dither source.
  lfs_dither #(
    .HALF_CYC (DITH_CYC)
  ) u_dither (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .factor_o  (factor_w)
  );

  // Dither factor retimed onto an output flop.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      freq_factor_o <= `LFS_PM_W'(`LFS_DITH_LO_PM);
    end else if (ce_i) begin
      freq_factor_o <= factor_w;
    end
  end

  // Checks on the supervisor behaviour.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  localparam logic [`LFS_PM_W-1:0] PM_LO = `LFS_PM_W'(`LFS_DITH_LO_PM);
  localparam logic [`LFS_PM_W-1:0] PM_HI = `LFS_PM_W'(`LFS_DITH_HI_PM);

  sequence s_trip;
    ce_i && (cmp_i.sec_ilim || cmp_i.in_trip || cmp_i.sw_ovp) &&
    !uv_lock_reg && !shdn_hit && state_reg != LFS_SHDN;
  endsequence

  sequence s_run_clean;
    ce_i && state_reg == LFS_RUN && !uv_lock_reg && !shdn_hit &&
    !trip_any && !cmp_i.frequency_program_pin_oc;
  endsequence

  uv_filter_a: assert property (
    $rose(uv_lock_reg) |-> $past(uv_cnt_reg) == UV_LIM && $past(uv_low_i))
    else $error("undervoltage lock without full delay");
  uv_off_a: assert property (
    ce_i && uv_lock_reg |=> !boost_en_o && !disc_gate_en_o &&
    sink_en_o == '0 && (latch_reg & ~$past(latch_set)) == '0)
    else $error("lockout left outputs or faults active");
  shdn_enter_a: assert property (
    ce_i && shdn_hit && !uv_lock_reg |=> shutdown_o && state_reg == LFS_SHDN)
    else $error("shutdown not entered after low time");
  shdn_clear_a: assert property (
    ce_i && shdn_hit && latch_set == '0 |=> latch_reg == '0)
    else $error("shutdown kept a latched fault");
  shdn_quiet_a: assert property (
    shutdown_o |-> !boost_en_o && !disc_gate_en_o && sink_en_o == '0)
    else $error("source active in shutdown");
  dith_range_a: assert property (
    freq_factor_o >= PM_LO && freq_factor_o <= PM_HI)
    else $error("dither factor out of range");
  dith_slope_a: assert property (
    ce_i ##1 ce_i |=>
    (freq_factor_o - $past(freq_factor_o) <= `LFS_PM_W'(1)) ||
    ($past(freq_factor_o) - freq_factor_o <= `LFS_PM_W'(1)))
    else $error("dither factor jumped");
  cycle_limit_a: assert property (
    s_run_clean and cmp_i.cyc_ilim |=> on_kill_o && disc_gate_en_o &&
    fault_n_o)
    else $error("cycle limit handled wrongly");
  latch_trip_a: assert property (
    s_trip |=> !boost_en_o && !disc_gate_en_o && sink_en_o == '0 &&
    !fault_n_o)
    else $error("latched trip did not shut off");
  latch_hold_a: assert property (
    ce_i && state_reg == LFS_LATCH && !shdn_hit && !uv_lock_reg |=>
    state_reg == LFS_LATCH)
    else $error("latched fault released early");
  short_hold_a: assert property (
    ce_i && state_reg == LFS_START && (|led_short_i) && !trip_any &&
    !shdn_hit && !uv_lock_reg && !cmp_i.frequency_program_pin_oc |=>
    state_reg == LFS_START && disc_gate_en_o && !boost_en_o && fault_n_o)
    else $error("startup short not held off");
  open_drop_a: assert property (
    s_run_clean and cmp_i.out_ovp |=> (mask_reg & $past(led_noreg_i)) == '0)
    else $error("open string kept after overvoltage");
  led_current_program_pin_a: assert property (
    s_run_clean and cmp_i.led_current_program_pin_oc |=> !boost_en_o && sink_en_o == '0 &&
    disc_gate_en_o && fault_n_o)
    else $error("program pin overcurrent handled wrongly");
  frequency_program_pin_a: assert property (
    ce_i && state_reg == LFS_RUN && !uv_lock_reg && !shdn_hit &&
    !trip_any && cmp_i.frequency_program_pin_oc |=> state_reg == LFS_START &&
    !disc_gate_en_o && !fault_n_o)
    else $error("frequency pin overcurrent handled wrongly");
  ovp_a: assert property (
    s_run_clean and cmp_i.out_ovp |=> !boost_en_o && disc_gate_en_o &&
    fault_n_o)
    else $error("output overvoltage handled wrongly");
  flag_a: assert property (state_reg == LFS_LATCH |-> !fault_n_o)
    else $error("fault flag not low while latched");
  dim_restart_a: assert property (
    ce_i && dim_i |=> dim_cnt_reg == '0)
    else $error("low-time counter not restarted");
endmodule

// File: tb/lfs_stage_model.sv
// Behavioural soft-start ramp of the boost stage seen by the supervisor.
`timescale 1ns/10ps
module lfs_stage_model #(
  parameter int SS_CYC = 8
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic disc_gate_en_i,
  output logic      ss_done_o
);
  int ramp_reg;
  // The ramp only builds while input power is connected; losing it discharges.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !disc_gate_en_i) begin
      ramp_reg <= 0;
    end else if (ramp_reg < SS_CYC) begin
      ramp_reg <= ramp_reg + 1;
    end
  end
  // Soft-start is reported finished once the ramp has reached its top.
  assign ss_done_o = (ramp_reg >= SS_CYC);
endmodule

// File: tb/testbench.sv
// Self-checking testbench of the LED fault supervisor.
`timescale 1ns/10ps
module testbench;
  import lfs_pkg::*;
  localparam int SHDN = 20;
  localparam int UVC  = 5;
  localparam int DITH = 800;
  logic             clk_i = 1'b0;
  logic             sys_rst_i = 1'b1;
  logic             uv_low_i = 1'b0;
  logic             dim_i = 1'b1;
  logic             ce_i = 1'b1;
  logic             ss_done;
  lfs_cmp_s         cmp = '0;
  logic [3:0]       led_short_i = 4'h0;
  logic [3:0]       led_noreg_i = 4'h0;
  logic             boost_en_o;
  logic             on_kill_o;
  logic             disc_gate_en_o;
  logic [3:0]       sink_en_o;
  logic             fault_n_o;
  logic             shutdown_o;
  logic             raise_vout_o;
  logic [10:0]      freq_factor_o;
  int               error_cnt = 0;
  int               checked = 0;
  int               cyc_cnt = 0;
  // Clock of 50 ns period.
  always #25 clk_i = ~clk_i;
  lfs_supervisor #(.N_LED(4), .SHDN_CYC(SHDN), .UV_CYC(UVC),
                   .DITH_CYC(DITH)) DUT (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .uv_low_i(uv_low_i), .dim_i(dim_i), .ss_done_i(ss_done),
    .cmp_i(cmp), .led_short_i(led_short_i), .led_noreg_i(led_noreg_i),
    .boost_en_o(boost_en_o), .on_kill_o(on_kill_o),
    .disc_gate_en_o(disc_gate_en_o), .sink_en_o(sink_en_o),
    .fault_n_o(fault_n_o), .shutdown_o(shutdown_o),
    .raise_vout_o(raise_vout_o), .freq_factor_o(freq_factor_o));
  lfs_stage_model #(.SS_CYC(8)) stage (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .disc_gate_en_i(disc_gate_en_o), .ss_done_o(ss_done));
  // Ends the run with the counts and the verdict.
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Cuts a hang short.
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 10000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask
  // Compares boost, disconnect gate, sinks and fault flag together.
  task automatic chk_out(input logic [6:0] exp);
    chk({9'h000, boost_en_o, disc_gate_en_o, sink_en_o, fault_n_o},
        {9'h000, exp});
  endtask
  // Waits, bounded, for switching to resume and checks full operation.
  task automatic restart;
    for (int i = 0; i < 100 && boost_en_o !== 1'b1; i++) cyc(1);
    cyc(1);
    chk_out(7'h7F);
  endtask
  task automatic t_startup;
    led_short_i = 4'h4;
    sys_rst_i = 1'b0;
    cyc(12);
    chk_out(7'h21);
    led_short_i = 4'h0;
    restart();
    $display("Test startup done");
  endtask
  task automatic t_cycle_limit;
    cmp.cyc_ilim = 1'b1;
    cyc(1);
    cmp.cyc_ilim = 1'b0;
    chk({15'h0000, on_kill_o}, 16'h0001);
    chk_out(7'h7F);
    cyc(1);
    chk({15'h0000, on_kill_o}, 16'h0000);
    $display("Test cycle limit done");
  endtask
  task automatic t_led_current_program_pin;
    cmp.led_current_program_pin_oc = 1'b1;
    cyc(2);
    chk_out(7'h21);
    cmp.led_current_program_pin_oc = 1'b0;
    cyc(2);
    chk_out(7'h7F);
    $display("Test program pin done");
  endtask
  task automatic t_ovp;
    led_noreg_i = 4'h2;
    cyc(1);
    chk({15'h0000, raise_vout_o}, 16'h0001);
    cmp.out_ovp = 1'b1;
    cyc(2);
    chk_out(7'h3B);
    chk({15'h0000, raise_vout_o}, 16'h0000);
    cmp.out_ovp = 1'b0;
    led_noreg_i = 4'h0;
    cyc(2);
    chk_out(7'h7B);
    $display("Test overvoltage done");
  endtask
  // Host holds the dimming input low, with a boundary check on the count.
  task automatic dim_shutdown;
    dim_i = 1'b0;
    cyc(SHDN);
    chk({15'h0000, shutdown_o}, 16'h0000);
    cyc(3);
    chk({15'h0000, shutdown_o}, 16'h0001);
    chk_out(7'h01);
    cyc(4);
    chk_out(7'h01);
    dim_i = 1'b1;
    restart();
  endtask
  task automatic t_latch(input int b);
    cmp[b] = 1'b1;
    cyc(1);
    cmp[b] = 1'b0;
    chk_out(7'h00);
    cyc(6);
    chk_out(7'h00);
    dim_shutdown();
    $display("Test latched fault %0d done", b);
  endtask
  task automatic t_dim_glitch;
    dim_i = 1'b0;
    cyc(SHDN);
    dim_i = 1'b1;
    cyc(1);
    dim_i = 1'b0;
    cyc(SHDN);
    chk({15'h0000, shutdown_o}, 16'h0000);
    dim_i = 1'b1;
    cyc(2);
    chk_out(7'h7F);
    $display("Test dimming glitch done");
  endtask
  task automatic t_frequency_program_pin;
    cmp.frequency_program_pin_oc = 1'b1;
    cyc(3);
    chk_out(7'h00);
    cmp.frequency_program_pin_oc = 1'b0;
    restart();
    $display("Test frequency pin done");
  endtask
  task automatic t_uvlo;
    uv_low_i = 1'b1;
    cyc(UVC);
    uv_low_i = 1'b0;
    cyc(3);
    chk_out(7'h7F);
    cmp.in_trip = 1'b1;
    cyc(1);
    cmp.in_trip = 1'b0;
    uv_low_i = 1'b1;
    cyc(UVC + 4);
    chk_out(7'h01);
    uv_low_i = 1'b0;
    restart();
    $display("Test undervoltage done");
  endtask
  // A trip seen while the clock enable is low must leave all state alone.
  task automatic t_freeze;
    ce_i = 1'b0;
    cmp.in_trip = 1'b1;
    cyc(3);
    chk_out(7'h7F);
    cmp.in_trip = 1'b0;
    ce_i = 1'b1;
    cyc(2);
    chk_out(7'h7F);
    $display("Test clock enable done");
  endtask
  task automatic t_dither;
    logic [10:0] f [0:4*DITH-1];
    logic [10:0] lo;
    logic [10:0] hi;
    lo = 11'h7FF;
    hi = 11'h000;
    for (int i = 0; i < 4 * DITH; i++) begin
      cyc(1);
      f[i] = freq_factor_o;
      if (f[i] < lo) lo = f[i];
      if (f[i] > hi) hi = f[i];
      chk({15'h0000, (f[i] >= 11'h3B6 && f[i] <= 11'h41A)}, 16'h0001);
    end
    chk({5'h00, lo}, 16'h03B6);
    chk({5'h00, hi}, 16'h041A);
    for (int i = 0; i < 2 * DITH; i++) begin
      chk({5'h00, f[i + 2 * DITH]}, {5'h00, f[i]});
    end
    $display("Test dither done");
  endtask
  // Main sequence.
  initial begin
    cyc(4);
    chk_out(7'h01);
    chk({5'h00, freq_factor_o}, 16'h03B6);
    t_startup();
    t_cycle_limit();
    t_led_current_program_pin();
    t_ovp();
    for (int b = 5; b >= 3; b--) t_latch(b);
    t_dim_glitch();
    t_frequency_program_pin();
    t_uvlo();
    t_freeze();
    t_dither();
    tally_and_finish();
  end
endmodule
